// ### logic/mpbc_pkg.sv
// Purpose: Constants for the microphone bias and PGA control block.
// Assumes: Paged 8-bit register port, page 0 and page 1 only.
// Notes: Gains are kept in half-dB units throughout.
package mpbc_pkg;
  // Pages
  localparam logic PAGE_0 = 1'h0;
  localparam logic PAGE_1 = 1'h1;
  // Register offsets
  localparam logic [6:0] ADC_GAIN_STATUS = 7'h24;
  localparam logic [6:0] ADC_POWER_SOFTSTEP_CTRL = 7'h51;
  localparam logic [6:0] ADC_MUTE_CTRL = 7'h52;
  localparam logic [6:0] AUTO_GAIN_CTRL = 7'h56;
  localparam logic [6:0] MIC_BIAS_LEVEL = 7'h2e;
  localparam logic [6:0] MIC_GAIN_CODE = 7'h2f;
  localparam logic [6:0] INPUT_RESISTANCE_SELECT_POS = 7'h30;
  localparam logic [6:0] INPUT_RESISTANCE_SELECT_NEG = 7'h31;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] SOFTSTEP_ON = 2'h0;
  // Field positions
  localparam int TOP_BIT = 7;
  localparam int PWR_UP_BIT = 7;
  localparam int STAT_REACHED_BIT = 7;
  localparam int STAT_PWR_BIT = 6;
  localparam int SS_DISABLE_BIT = 1;
  localparam int LP_RES_LSB = 6;
  localparam int RP_RES_LSB = 4;
  localparam int LM_RES_LSB = 2;
  // Gain codes in half-dB
  localparam logic [6:0] GAIN_CODE_MAX = 7'h77;
  localparam logic [6:0] GAIN_CODE_ZERO = 7'h00;
  localparam logic signed [8:0] OFS_PLUS_6DB = 9'sh00c;
  localparam logic signed [8:0] OFS_ZERO = 9'sh000;
  localparam logic signed [8:0] OFS_DIFF_EXTRA = 9'sh00c;
  // Resistance select codes
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_10K = 2'h1;
  // Bias select one-hot encodings
  typedef enum logic [1:0] {BIAS_OFF, BIAS_2V0, BIAS_2V5, BIAS_SUPPLY} mpbc_bias_t;
  localparam logic [3:0] BIAS_OH_OFF = 4'h1;
  localparam logic [3:0] BIAS_OH_2V0 = 4'h2;
  localparam logic [3:0] BIAS_OH_2V5 = 4'h4;
  localparam logic [3:0] BIAS_OH_SUPPLY = 4'h8;
  // Default soft-step divider ratio
  localparam int SS_DIV_DEFAULT = 4;
endpackage : mpbc_pkg

// ### logic/mpbc_top.sv
// Purpose: Register-side control of mic bias, mic PGA gain, soft-step and ADC mute.
// Assumes: Oscillator tick is asynchronous; AGC gain and samples share i_clk_sys.
// Notes: Applied gain is a code plus a mute state; mute sits below code 0.
`timescale 1ns/1ns
module mpbc_top #(
  parameter int SS_DIV = mpbc_pkg::SS_DIV_DEFAULT,
  parameter int SAMPLE_W = 24
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_page,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Internal oscillator and AGC loop
  input wire logic i_osc_clk,
  input wire logic [6:0] i_agc_gain,
  // ADC sample path
  input wire logic i_adc_valid,
  input wire logic [SAMPLE_W-1:0] i_adc_sample,
  output logic o_adc_valid,
  output logic [SAMPLE_W-1:0] o_adc_sample,
  // Analog controls
  output logic [3:0] o_mic_bias_supply_sel,
  output logic [6:0] o_pga_code,
  output logic o_pga_muted,
  output logic o_adc_power,
  output logic signed [8:0] o_left_positive_mic_input_gain,
  output logic signed [8:0] o_right_positive_mic_input_gain,
  output logic signed [8:0] o_left_negative_mic_input_gain,
  output logic signed [8:0] o_diff_gain
);
  import mpbc_pkg::*;

  logic [7:0] pwr_ss_reg, mute_reg, agc_reg, bias_reg, gain_reg, res_pos_reg, res_neg_reg;
  logic [6:0] code_reg, code_next, target_code;
  logic muted_reg, muted_next, target_mute, pwr_flag_reg, reached;
  logic ss_en, step;
  logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
  logic [$clog2(SS_DIV+1)-1:0] div_reg;

  // Resistance offset in half-dB for one input field
  function automatic logic signed [8:0] res_ofs(input logic [1:0] sel);
    logic signed [8:0] ofs;
    ofs = OFS_ZERO;
    if (sel == RES_10K) begin
      ofs = OFS_PLUS_6DB;
    end else if (sel != RES_NONE) begin
      ofs = -OFS_PLUS_6DB;
    end
    return ofs;
  endfunction : res_ofs

  // Register writes
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      pwr_ss_reg <= {6'h00, SOFTSTEP_ON};
      mute_reg <= RST_ZERO;
      agc_reg <= RST_ZERO;
      bias_reg <= RST_ZERO;
      gain_reg <= RST_ZERO;
      res_pos_reg <= RST_ZERO;
      res_neg_reg <= RST_ZERO;
    end else if (i_reg_wr) begin
      if (i_reg_page == PAGE_0) begin
        if (i_reg_addr == ADC_POWER_SOFTSTEP_CTRL) pwr_ss_reg <= i_reg_wdata;
        if (i_reg_addr == ADC_MUTE_CTRL) mute_reg <= i_reg_wdata;
        if (i_reg_addr == AUTO_GAIN_CTRL) agc_reg <= i_reg_wdata;
      end else begin
        if (i_reg_addr == MIC_BIAS_LEVEL) bias_reg <= i_reg_wdata;
        if (i_reg_addr == MIC_GAIN_CODE) gain_reg <= i_reg_wdata;
        if (i_reg_addr == INPUT_RESISTANCE_SELECT_POS) res_pos_reg <= i_reg_wdata;
        if (i_reg_addr == INPUT_RESISTANCE_SELECT_NEG) res_neg_reg <= i_reg_wdata;
      end
    end
  end

  // Register reads, unmapped reads return zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_reg_rdata <= RST_ZERO;
    end else if (i_reg_rd) begin
      o_reg_rdata <= RST_ZERO;
      if (i_reg_page == PAGE_0) begin
        if (i_reg_addr == ADC_GAIN_STATUS) begin
          o_reg_rdata[STAT_REACHED_BIT] <= reached;
          o_reg_rdata[STAT_PWR_BIT] <= pwr_flag_reg;
        end
        if (i_reg_addr == ADC_POWER_SOFTSTEP_CTRL) o_reg_rdata <= pwr_ss_reg;
        if (i_reg_addr == ADC_MUTE_CTRL) o_reg_rdata <= mute_reg;
        if (i_reg_addr == AUTO_GAIN_CTRL) o_reg_rdata <= agc_reg;
      end else begin
        if (i_reg_addr == MIC_BIAS_LEVEL) o_reg_rdata <= bias_reg;
        if (i_reg_addr == MIC_GAIN_CODE) o_reg_rdata <= gain_reg;
        if (i_reg_addr == INPUT_RESISTANCE_SELECT_POS) o_reg_rdata <= res_pos_reg;
        if (i_reg_addr == INPUT_RESISTANCE_SELECT_NEG) o_reg_rdata <= res_neg_reg;
      end
    end
  end

  // Bias level decode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_mic_bias_supply_sel <= BIAS_OH_OFF;
    end else begin
      unique case (mpbc_bias_t'(bias_reg[1:0]))
        BIAS_OFF: o_mic_bias_supply_sel <= BIAS_OH_OFF;
        BIAS_2V0: o_mic_bias_supply_sel <= BIAS_OH_2V0;
        BIAS_2V5: o_mic_bias_supply_sel <= BIAS_OH_2V5;
        BIAS_SUPPLY: o_mic_bias_supply_sel <= BIAS_OH_SUPPLY;
      endcase
    end
  end

  // Oscillator synchroniser and edge detect
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= i_osc_clk;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  // Soft-step divider on oscillator edges, codec clock not used
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      div_reg <= '0;
    end else if (osc_s2_reg && !osc_s3_reg) begin
      div_reg <= (div_reg == ($clog2(SS_DIV+1))'(SS_DIV - 1)) ? '0 : div_reg + 1'b1;
    end
  end
  assign step = osc_s2_reg && !osc_s3_reg && (div_reg == '0);

  // Target selection: AGC or fixed code, PGA disable forces 0 dB
  always_comb begin
    ss_en = !pwr_ss_reg[SS_DISABLE_BIT];
    target_mute = !pwr_ss_reg[PWR_UP_BIT];
    if (!gain_reg[TOP_BIT]) begin
      target_code = GAIN_CODE_ZERO;
    end else if (agc_reg[TOP_BIT]) begin
      target_code = i_agc_gain;
    end else begin
      target_code = gain_reg[6:0];
    end
    if (target_code > GAIN_CODE_MAX) begin
      target_code = GAIN_CODE_MAX;
    end
  end

  // Next applied gain: jump, or one half-dB step per tick
  always_comb begin
    code_next = code_reg;
    muted_next = muted_reg;
    if (!ss_en) begin
      code_next = target_mute ? GAIN_CODE_ZERO : target_code;
      muted_next = target_mute;
    end else if (step) begin
      if (muted_reg) begin
        muted_next = target_mute;
      end else if (target_mute && code_reg == GAIN_CODE_ZERO) begin
        muted_next = 1'b1;
      end else if (target_mute || code_reg > target_code) begin
        code_next = code_reg - 1'b1;
      end else if (code_reg < target_code) begin
        code_next = code_reg + 1'b1;
      end
    end
  end
  assign reached = (muted_reg == target_mute) && (target_mute || code_reg == target_code);

  // Applied gain state, muted out of reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      code_reg <= GAIN_CODE_ZERO;
      muted_reg <= 1'b1;
    end else begin
      code_reg <= code_next;
      muted_reg <= muted_next;
    end
  end

  // Powered-up flag clears only once the ramp to mute completes
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      pwr_flag_reg <= 1'b0;
      o_adc_power <= 1'b0;
    end else begin
      if (pwr_ss_reg[PWR_UP_BIT]) begin
        pwr_flag_reg <= 1'b1;
      end else if (muted_reg) begin
        pwr_flag_reg <= 1'b0;
      end
      o_adc_power <= pwr_ss_reg[PWR_UP_BIT] || !muted_reg;
    end
  end

  // Applied gain and per-input effective gain outputs
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_pga_code <= GAIN_CODE_ZERO;
      o_pga_muted <= 1'b1;
      o_left_positive_mic_input_gain <= OFS_ZERO;
      o_right_positive_mic_input_gain <= OFS_ZERO;
      o_left_negative_mic_input_gain <= OFS_ZERO;
      o_diff_gain <= OFS_ZERO;
    end else begin
      o_pga_code <= code_reg;
      o_pga_muted <= muted_reg;
      o_left_positive_mic_input_gain <= $signed({2'b00, code_reg})
        + res_ofs(res_pos_reg[LP_RES_LSB +: 2]);
      o_right_positive_mic_input_gain <= $signed({2'b00, code_reg})
        + res_ofs(res_pos_reg[RP_RES_LSB +: 2]);
      o_left_negative_mic_input_gain <= $signed({2'b00, code_reg})
        + res_ofs(res_pos_reg[LM_RES_LSB +: 2]);
      o_diff_gain <= $signed({2'b00, code_reg}) + OFS_DIFF_EXTRA
        + res_ofs(res_pos_reg[LP_RES_LSB +: 2]);
    end
  end

  // ADC output holds its value while muted
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_adc_valid <= 1'b0;
      o_adc_sample <= '0;
    end else begin
      o_adc_valid <= i_adc_valid;
      if (i_adc_valid && !mute_reg[TOP_BIT]) begin
        o_adc_sample <= i_adc_sample;
      end
    end
  end
endmodule : mpbc_top

// ### bench/mpbc_properties.sv
// Purpose: Port assertions for mpbc_top.
// Assumes: Soft-step and mute bits are tracked from register writes.
// Notes: Bound to every mpbc_top at the foot of this file.
`timescale 1ns/1ns
module mpbc_properties #(
  parameter int SAMPLE_W = 24
) (
  // Clock, reset and register port
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_page,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Sample path and analog controls
  input wire logic i_adc_valid,
  input wire logic [SAMPLE_W-1:0] i_adc_sample,
  input wire logic o_adc_valid,
  input wire logic [SAMPLE_W-1:0] o_adc_sample,
  input wire logic [3:0] o_mic_bias_supply_sel,
  input wire logic [6:0] o_pga_code,
  input wire logic o_pga_muted,
  input wire logic signed [8:0] o_left_positive_mic_input_gain,
  input wire logic signed [8:0] o_diff_gain
);
  import mpbc_pkg::*;
  logic ss_off_q;
  logic mute_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // Shadow of soft-step disable and ADC mute bits
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ss_off_q <= 1'b0;
      mute_q <= 1'b0;
    end else if (i_reg_wr && !i_reg_page) begin
      if (i_reg_addr == ADC_POWER_SOFTSTEP_CTRL) ss_off_q <= i_reg_wdata[SS_DISABLE_BIT];
      if (i_reg_addr == ADC_MUTE_CTRL) mute_q <= i_reg_wdata[7];
    end
  end
  a_bias_onehot: assert property ($onehot(o_mic_bias_supply_sel))
    else $error("bias select not one-hot");
  a_code_range: assert property (o_pga_code <= GAIN_CODE_MAX)
    else $error("gain code above range");
  a_step_one: assert property (!ss_off_q && !$past(ss_off_q) && !$past(ss_off_q, 2)
    |-> (o_pga_code - $past(o_pga_code)) inside {7'h00, 7'h01, 7'h7f})
    else $error("gain moved more than one step");
  a_reset_muted: assert property ($rose(i_rstn) |-> o_pga_muted && o_pga_code == 7'h00)
    else $error("stage not muted after reset");
  a_diff_gain: assert property (!o_pga_muted && !$past(o_pga_muted)
    |-> o_diff_gain == o_left_positive_mic_input_gain + 9'sh00c)
    else $error("differential gain offset wrong");
  a_status_zero: assert property (i_reg_rd && !i_reg_page && i_reg_addr == ADC_GAIN_STATUS
    |=> o_reg_rdata[5:0] == 6'h00)
    else $error("status low bits not zero");
  a_mute_hold: assert property (mute_q && !i_reg_wr |=> $stable(o_adc_sample))
    else $error("muted sample changed");
  a_pass_thru: assert property (i_adc_valid && !mute_q && !i_reg_wr
    |=> o_adc_sample == $past(i_adc_sample))
    else $error("sample not passed");
  a_valid_delay: assert property (i_rstn |=> o_adc_valid == $past(i_adc_valid))
    else $error("sample strobe not delayed by one cycle");
endmodule : mpbc_properties
bind mpbc_top mpbc_properties #(.SAMPLE_W(SAMPLE_W)) u_props (.i_clk_sys, .i_rstn, .i_reg_wr,
  .i_reg_rd, .i_reg_page, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_adc_valid, .i_adc_sample,
  .o_adc_valid, .o_adc_sample, .o_mic_bias_supply_sel, .o_pga_code, .o_pga_muted,
  .o_left_positive_mic_input_gain, .o_diff_gain);

// ### bench/mpbc_far_model.sv
// Purpose: Oscillator and ADC sample source beside the block.
// Assumes: Samples share the system clock.
// Notes: Oscillator runs free, unrelated to the system clock.
`timescale 1ns/1ns
module mpbc_far_model (
  // System clock
  input wire logic i_clk_sys,
  // Oscillator and samples
  output logic o_osc_clk,
  output logic o_adc_valid,
  output logic [23:0] o_adc_sample
);
  logic [2:0] cnt = 3'h0;
  // Free oscillator apart from the codec clock
  initial begin
    o_osc_clk = 1'b0;
    forever #85 o_osc_clk = !o_osc_clk;
  end
  // One new sample every eight cycles
  always @(posedge i_clk_sys) begin
    cnt <= cnt + 3'h1;
    o_adc_valid <= (cnt == 3'h0);
    if (cnt == 3'h0) o_adc_sample <= o_adc_sample + 24'h01_0101;
  end
  initial o_adc_sample = 24'h00_0000;
  initial o_adc_valid = 1'b0;
endmodule : mpbc_far_model

// ### bench/tb_top.sv
// Purpose: Register-level tests of mpbc_top.
// Assumes: SS_DIV of 1 so soft-step ticks follow each rising oscillator edge.
// Notes: Expected values follow the gain, offset and status definitions.
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic pg = 1'b0;
  logic [6:0] ad = 7'h00;
  logic [7:0] wd = 8'h00;
  logic [6:0] agc = 7'h21;
  logic [7:0] rdata;
  logic osc, iv, ov, muted, pwr;
  logic [23:0] is, smp, hold;
  logic [3:0] bias;
  logic [6:0] code;
  logic signed [8:0] lp, rp, ln, dg;
  int failures = 0;
  int n_tests = 0;
  mpbc_far_model i_far (.i_clk_sys(clk), .o_osc_clk(osc), .o_adc_valid(iv), .o_adc_sample(is));
  mpbc_top #(.SS_DIV(1)) i_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_reg_wr(wr_s),
    .i_reg_rd(rd_s), .i_reg_page(pg), .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .i_osc_clk(osc), .i_agc_gain(agc), .i_adc_valid(iv), .i_adc_sample(is), .o_adc_valid(ov),
    .o_adc_sample(smp), .o_mic_bias_supply_sel(bias), .o_pga_code(code), .o_pga_muted(muted),
    .o_adc_power(pwr), .o_left_positive_mic_input_gain(lp),
    .o_right_positive_mic_input_gain(rp), .o_left_negative_mic_input_gain(ln), .o_diff_gain(dg));
  initial begin
    forever #25 clk = !clk;
  end
  task automatic chk(input logic signed [23:0] g, input logic signed [23:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic p, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= w;
    rd_s <= !w;
    pg <= p;
    ad <= a;
    wd <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask : acc
  task automatic rd(input logic p, input logic [6:0] a, input logic [7:0] e);
    acc(1'b0, p, a, 8'h00);
    #1;
    chk(rdata, e);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Bounded wait for an applied code and mute state
  task automatic wait_code(input logic [6:0] c, input logic m);
    int k;
    k = 0;
    while ((code !== c || muted !== m) && k < 400) begin
      @(posedge clk);
      k++;
    end
    #1;
    chk({muted, code}, {m, c});
  endtask : wait_code
  task automatic tally_and_finish;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hung sequence
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end
  initial begin
    int off;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(muted, 1);
    rd(0, 7'h24, 8'h80);
    for (int b = 0; b < 4; b++) begin
      acc(1, 1, 7'h2e, 8'(b));
      cyc(2);
      chk(bias, 4'h1 << b);
    end
    acc(1, 0, 7'h51, 8'h80);
    acc(1, 1, 7'h2f, 8'h86);
    rd(0, 7'h24, 8'h40);
    wait_code(7'h06, 0);
    chk(code, 6);
    rd(0, 7'h24, 8'hc0);
    // Every resistance code on all three inputs
    for (int r = 0; r < 4; r++) begin
      acc(1, 1, 7'h30, {r[1:0], r[1:0], r[1:0], 2'h0});
      cyc(3);
      off = (r == 0) ? 0 : (r == 1) ? 12 : -12;
      chk(lp, 6 + off);
      chk(rp, 6 + off);
      chk(ln, 6 + off);
      chk(dg, 18 + off);
    end
    acc(1, 0, 7'h51, 8'h82);
    acc(1, 1, 7'h2f, 8'hff);
    cyc(4);
    chk(code, 7'h77);
    acc(1, 0, 7'h56, 8'h80);
    cyc(4);
    chk(code, 7'h21);
    @(posedge clk);
    agc <= 7'h15;
    cyc(4);
    chk(code, 7'h15);
    acc(1, 0, 7'h56, 8'h00);
    rd(1, 7'h2f, 8'hff);
    acc(1, 1, 7'h2f, 8'h77);
    cyc(4);
    chk({muted, code}, 0);
    acc(1, 0, 7'h52, 8'h80);
    cyc(2);
    hold = smp;
    cyc(20);
    chk(smp, hold);
    acc(1, 0, 7'h52, 8'h00);
    cyc(20);
    chk(smp !== hold, 1);
    acc(1, 0, 7'h51, 8'h80);
    acc(1, 1, 7'h2f, 8'h83);
    wait_code(7'h03, 0);
    acc(1, 0, 7'h51, 8'h00);
    rd(0, 7'h24, 8'h40);
    chk(pwr, 1);
    wait_code(7'h00, 1);
    rd(0, 7'h24, 8'h80);
    chk(pwr, 0);
    rd(0, 7'h7f, 8'h00);
    acc(1, 0, 7'h24, 8'hff);
    rd(0, 7'h24, 8'h80);
    tally_and_finish();
  end
endmodule : tb_top
